/* core/fms_pkg.sv */
// constants for the flash mode and status control block
package fms_pkg;
    // opcodes
    localparam logic [7:0] OP_QUAD_EN   = 8'h38;
    localparam logic [7:0] OP_QUAD_EXIT = 8'hFF;
    localparam logic [7:0] OP_ARM       = 8'h66;
    localparam logic [7:0] OP_FIRE      = 8'h99;
    localparam logic [7:0] OP_UNLOCK    = 8'h06;
    localparam logic [7:0] OP_LOCK      = 8'h04;
    localparam logic [7:0] OP_ST_READ   = 8'h05;
    localparam logic [7:0] OP_ST_WRITE  = 8'h01;
    localparam logic [7:0] OP_PAGE      = 8'h02;
    localparam logic [7:0] OP_WIPE_SM   = 8'h20;
    localparam logic [7:0] OP_WIPE_HB   = 8'h52;
    localparam logic [7:0] OP_WIPE_LG   = 8'hD8;
    localparam logic [7:0] OP_WIPE_ALL  = 8'hC7;
    localparam logic [7:0] OP_WIPE_ALL2 = 8'h60;
    localparam logic [7:0] OP_OTP_ENTER = 8'h3A;
    localparam logic [7:0] OP_READ      = 8'h03;
    localparam logic [7:0] OP_READ_DO   = 8'h3B;
    localparam logic [7:0] OP_READ_DIO  = 8'hBB;
    // status field positions and reset value
    localparam int         ST_BUSY    = 0;
    localparam int         ST_LATCH   = 1;
    localparam int         ST_AREA_LO = 2;
    localparam int         ST_PIN_IGN = 6;
    localparam int         ST_LOCK    = 7;
    localparam logic [7:0] STAT_RST   = 8'h00;
    // frame lengths in link clocks
    localparam logic [4:0] OP_CLKS_1 = 5'h08;
    localparam logic [4:0] OP_CLKS_4 = 5'h02;
    localparam logic [4:0] ST_CLKS_1 = 5'h10;
    localparam logic [4:0] ST_CLKS_4 = 5'h04;
    localparam logic [4:0] CNT_MAX   = 5'h1F;
    localparam logic [2:0] RB_WRAP_1 = 3'h7;
    localparam logic [2:0] RB_WRAP_4 = 3'h1;
    // recovery after an aborted write
    localparam int ABORT_NS  = 28000;
    localparam int CLK_NS    = 5;
    localparam int ABORT_CYC = ABORT_NS / CLK_NS;
    typedef enum logic [1:0] {
        K_IDLE, K_STAT, K_WRITE, K_RECOV
    } fms_kind_t;
endpackage

/* core/fms_ctrl.sv */
// flash command interpreter: lane mode, soft reset, latch, status
//
// Behaviour
// - quad enable makes all later opcodes four-lane until power, exit or soft reset
// - plain, dual-output and dual-io reads refused in four-lane mode
// - exit opcode returns to single lane; ignored in single-lane mode
// - exit first releases continuous quad read, a second leaves quad
// - reset fires only on arm frame followed by fire frame
// - any other opcode after arming cancels the armed state
// - soft reset returns to ready and zeroes status and info
// - soft reset aborts a running write; recovery up to 28 us
// - soft reset does not leave deep power-down
// - unlock opcode alone in a frame sets the write latch
// - lock opcode alone clears the latch and leaves otp mode
// - latch clears at power-up and when a write completes
// - status readback accepted any time, repeats continuously
// - status bit 0 is busy during status write, program, erase
// - status bit 1 is the latch; clear latch refuses writes
// - area field bits 5:2 refuse writes into its region
// - whole-chip erase only when the area field is zero
// - bit 6 set disables the protect pin; quad use unaffected
// - lock bit and low pin freeze bits 7:2 and refuse updates, in single-lane mode only
// - otp mode: status update ignores data and sets sector lock
// - opcode takes eight clocks single lane, two in quad
// - all bytes shift most significant bit first
`timescale 1ns/1ps
module fms_ctrl #(
    parameter int unsigned ABORT_CYC = fms_pkg::ABORT_CYC
) (
    // system
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic       CE,
    // serial link
    input  wire logic       SCK,
    input  wire logic       CS_N,
    input  wire logic [3:0] DQ_I,
    output logic      [3:0] DQ_O,
    output logic      [3:0] DQ_OE_N,
    input  wire logic       WP_N,
    // array engine
    output logic            OP_REQ,
    output logic      [7:0] OP_CODE,
    output logic            OP_ABORT,
    input  wire logic       OP_DONE,
    input  wire logic       AREA_HIT,
    input  wire logic       CONT_SET,
    input  wire logic       PWR_DOWN,
    // state
    output logic            SOFT_RST,
    output logic            CMD_REJECT,
    output logic            QUAD_MODE,
    output logic      [7:0] STATUS
);
    typedef struct packed {
        logic                cs1, cs2, cs3, wp1, wp2;
        logic                quad, cont, arm, otp, olock;
        logic                latch, pign, slock;
        logic [3:0]          area;
        fms_pkg::fms_kind_t  kind;
        logic [12:0]         rcnt;
        logic [7:0]          pend, code, view;
        logic                req, abort, srst, rej;
    } fms_sys_t;
    typedef struct packed {
        logic [4:0] cnt;
        logic [7:0] op, dat, st1, st2;
    } fms_cap_t;
    typedef struct packed {
        logic       first, oe;
        logic [7:0] rd;
        logic [2:0] ph;
    } fms_lnk_t;

    localparam fms_sys_t SYS_RST = '{cs1: 1'b1, cs2: 1'b1, cs3: 1'b1,
        wp1: 1'b1, wp2: 1'b1, kind: fms_pkg::K_IDLE, default: '0};
    localparam fms_lnk_t LNK_RST = '{first: 1'b1, default: '0};

    fms_sys_t   q, n;
    fms_cap_t   cq, cn;
    fms_lnk_t   lq, ln;
    logic [4:0] oplen;
    logic       fe, done_op, alone, datok, busy, hwprot, w_op;
    logic       in_op, last_op;
    logic [7:0] op, sv;

    // ---------------- link domain ----------------
    // lane width is quasi-static: it only changes while CS_N is high
    assign oplen = q.quad ? fms_pkg::OP_CLKS_4 : fms_pkg::OP_CLKS_1;
    assign in_op = lq.first || (cq.cnt < oplen);
    assign last_op = !lq.first && (cq.cnt == oplen - 5'h01);

    always_comb begin
        cn = cq;
        ln = lq;
        cn.st1 = q.view;
        cn.st2 = cq.st1;
        ln.first = 1'b0;
        if (lq.first)
            cn.cnt = 5'h01;
        else if (cq.cnt != fms_pkg::CNT_MAX)
            cn.cnt = cq.cnt + 5'h01;
        if (in_op) begin
            cn.op = q.quad ? {cq.op[3:0], DQ_I} : {cq.op[6:0], DQ_I[0]};
        end else begin
            cn.dat = q.quad ? {cq.dat[3:0], DQ_I}
                            : {cq.dat[6:0], DQ_I[0]};
        end
        // readback needs no idle device and repeats until CS_N rises
        if (last_op && cn.op == fms_pkg::OP_ST_READ) begin
            ln.rd = cq.st2;
            ln.oe = 1'b1;
            ln.ph = 3'h0;
        end else if (lq.oe) begin
            if (lq.ph == (q.quad ? fms_pkg::RB_WRAP_4
                                 : fms_pkg::RB_WRAP_1)) begin
                ln.rd = cq.st2;
                ln.ph = 3'h0;
            end else begin
                ln.rd = q.quad ? {lq.rd[3:0], 4'h0} : {lq.rd[6:0], 1'b0};
                ln.ph = lq.ph + 3'h1;
            end
        end
    end

    always_ff @(posedge SCK) begin
        cq <= cn;
    end

    always_ff @(posedge SCK or posedge CS_N) begin
        if (CS_N) begin
            lq <= LNK_RST;
        end else begin
            lq <= ln;
        end
    end

    assign DQ_O = q.quad ? lq.rd[7:4] : {2'b00, lq.rd[7], 1'b0};
    assign DQ_OE_N = ~({4{lq.oe}} & (q.quad ? 4'hF : 4'h2));

    // ---------------- system domain ----------------
    // capture registers are stable once CS_N high has been synchronised
    assign fe = q.cs2 && !q.cs3 && !PWR_DOWN;
    assign done_op = cq.cnt >= oplen;
    assign alone = cq.cnt == oplen;
    assign datok = cq.cnt == (q.quad ? fms_pkg::ST_CLKS_4
                                     : fms_pkg::ST_CLKS_1);
    assign op = cq.op;
    assign busy = q.kind != fms_pkg::K_IDLE;
    // pin is a data lane in quad mode, so it protects only in single
    assign hwprot = q.slock && !q.wp2 && !q.pign && !q.quad;
    assign w_op = !q.latch || AREA_HIT || (q.otp && q.olock);

    always_comb begin
        n = q;
        n.cs1 = CS_N;
        n.cs2 = q.cs1;
        n.cs3 = q.cs2;
        n.wp1 = WP_N;
        n.wp2 = q.wp1;
        n.req = 1'b0;
        n.abort = 1'b0;
        n.srst = 1'b0;
        n.rej = 1'b0;
        if (q.kind == fms_pkg::K_RECOV) begin
            if (q.rcnt == 13'h0000)
                n.kind = fms_pkg::K_IDLE;
            else
                n.rcnt = q.rcnt - 13'h0001;
        end
        if (OP_DONE && (q.kind == fms_pkg::K_STAT ||
                        q.kind == fms_pkg::K_WRITE)) begin
            n.kind = fms_pkg::K_IDLE;
            n.latch = 1'b0;
            if (q.kind == fms_pkg::K_STAT) begin
                if (q.otp) begin
                    n.olock = 1'b1;
                end else begin
                    n.slock = q.pend[fms_pkg::ST_LOCK];
                    n.pign = q.pend[fms_pkg::ST_PIN_IGN];
                    n.area = q.pend[fms_pkg::ST_AREA_LO +: 4];
                end
            end
        end
        if (CONT_SET)
            n.cont = 1'b1;
        if (fe && done_op) begin
            n.arm = (op == fms_pkg::OP_ARM) && alone;
            if (op == fms_pkg::OP_FIRE && alone && q.arm) begin
                n.quad = 1'b0;
                n.cont = 1'b0;
                n.otp = 1'b0;
                n.latch = 1'b0;
                n.pign = 1'b0;
                n.slock = 1'b0;
                n.area = 4'h0;
                n.srst = 1'b1;
                n.kind = fms_pkg::K_IDLE;
                if (busy && q.kind != fms_pkg::K_RECOV) begin
                    n.abort = 1'b1;
                    n.kind = fms_pkg::K_RECOV;
                    n.rcnt = ABORT_CYC[12:0] - 13'h0001;
                end
            end else if (!busy) begin
                unique case (op)
                    fms_pkg::OP_QUAD_EN:
                        if (alone)
                            n.quad = 1'b1;
                    fms_pkg::OP_QUAD_EXIT:
                        if (q.cont)
                            n.cont = 1'b0;
                        else if (q.quad)
                            n.quad = 1'b0;
                    fms_pkg::OP_UNLOCK:
                        if (alone)
                            n.latch = 1'b1;
                    fms_pkg::OP_LOCK:
                        if (alone) begin
                            n.latch = 1'b0;
                            n.otp = 1'b0;
                        end
                    fms_pkg::OP_OTP_ENTER:
                        if (alone)
                            n.otp = 1'b1;
                    fms_pkg::OP_ST_WRITE:
                        if (!datok) begin
                        end else if (!q.latch || hwprot) begin
                            n.rej = 1'b1;
                        end else begin
                            n.kind = fms_pkg::K_STAT;
                            n.req = 1'b1;
                            n.code = op;
                            n.pend = cq.dat;
                        end
                    fms_pkg::OP_PAGE, fms_pkg::OP_WIPE_SM,
                    fms_pkg::OP_WIPE_HB, fms_pkg::OP_WIPE_LG:
                        if (w_op) begin
                            n.rej = 1'b1;
                        end else begin
                            n.kind = fms_pkg::K_WRITE;
                            n.req = 1'b1;
                            n.code = op;
                        end
                    fms_pkg::OP_WIPE_ALL, fms_pkg::OP_WIPE_ALL2:
                        if (!q.latch || q.area != 4'h0 || q.otp) begin
                            n.rej = 1'b1;
                        end else begin
                            n.kind = fms_pkg::K_WRITE;
                            n.req = 1'b1;
                            n.code = op;
                        end
                    fms_pkg::OP_READ, fms_pkg::OP_READ_DO,
                    fms_pkg::OP_READ_DIO:
                        n.rej = q.quad;
                    default: ;
                endcase
            end
        end
        sv = fms_pkg::STAT_RST;
        sv[fms_pkg::ST_BUSY] = n.kind != fms_pkg::K_IDLE;
        sv[fms_pkg::ST_LATCH] = n.latch;
        sv[fms_pkg::ST_AREA_LO +: 4] = n.area;
        sv[fms_pkg::ST_PIN_IGN] = n.pign;
        sv[fms_pkg::ST_LOCK] = n.otp ? n.olock : n.slock;
        n.view = sv;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            q <= SYS_RST;
        end else if (CE) begin
            q <= n;
        end
    end

    assign OP_REQ = q.req;
    assign OP_CODE = q.code;
    assign OP_ABORT = q.abort;
    assign SOFT_RST = q.srst;
    assign CMD_REJECT = q.rej;
    assign QUAD_MODE = q.quad;
    assign STATUS = q.view;

    // ---------------- checks ----------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    logic go;
    assign go = CE && fe && done_op && !busy;

    a_arm_then_fire: assert property (
        CE && fe && alone && op == fms_pkg::OP_FIRE && q.arm
        |=> q.srst && !q.quad && !q.latch && q.area == 4'h0)
        else $error("armed fire did not reset");
    a_fire_unarmed: assert property (
        CE && fe && !q.arm |=> !q.srst)
        else $error("reset without arming");
    a_arm_cancel: assert property (
        CE && fe && done_op && op != fms_pkg::OP_ARM |=> !q.arm)
        else $error("arm kept after other opcode");
    a_quad_enter: assert property (
        go && alone && op == fms_pkg::OP_QUAD_EN |=> q.quad ##1 q.quad)
        else $error("quad mode not entered");
    a_exit_single: assert property (
        go && op == fms_pkg::OP_QUAD_EXIT && !q.quad |=> !q.quad)
        else $error("exit acted in single lane");
    a_exit_two_step: assert property (
        go && op == fms_pkg::OP_QUAD_EXIT && q.cont && q.quad
        |=> q.quad && !q.cont)
        else $error("exit skipped continuous release");
    a_unlock_sets: assert property (
        go && alone && op == fms_pkg::OP_UNLOCK |=> q.latch ##1 STATUS[1])
        else $error("unlock did not set latch");
    a_lock_clears: assert property (
        go && alone && op == fms_pkg::OP_LOCK |=> !q.latch && !q.otp)
        else $error("lock did not clear latch");
    a_done_clears: assert property (
        CE && OP_DONE && q.kind == fms_pkg::K_WRITE
        |=> !q.latch ##1 !STATUS[0] && !STATUS[1])
        else $error("write end left latch or busy");
    a_latch_needed: assert property (
        go && op == fms_pkg::OP_PAGE && !q.latch |=> q.rej && !q.req)
        else $error("write accepted without latch");
    a_chip_area: assert property (
        go && op == fms_pkg::OP_WIPE_ALL && q.area != 4'h0 |=> q.rej)
        else $error("chip erase with area set");
    a_hw_protect: assert property (
        go && datok && op == fms_pkg::OP_ST_WRITE && hwprot
        |=> !q.req && q.rej)
        else $error("status update in protected state");
    a_abort_busy: assert property (
        q.abort |-> q.kind == fms_pkg::K_RECOV && STATUS[0]
        ##1 STATUS[0])
        else $error("abort without recovery busy");
    a_short_frame: assert property (
        CE && fe && !done_op && !OP_DONE && !CONT_SET
        |=> $stable(q.quad) && $stable(q.latch) && $stable(q.arm))
        else $error("short frame changed state");

    c_soft_reset: cover property (q.srst);
    c_quad_round: cover property (q.quad ##[1:200] !q.quad);
    c_write_done: cover property (q.req ##[1:300] !busy);
    c_reject: cover property (q.rej);
endmodule

/* testbench/fms_host.sv */
// host controller model: chip select, link clock and lanes
`timescale 1ns/1ps
module fms_host (
    // pacing
    input  wire logic       clk,
    // link
    output logic            cs_n,
    output logic            sck,
    output logic      [3:0] dq_i,
    input  wire logic [3:0] dq_o
);
    initial begin
        cs_n = 1'b0;
        sck  = 1'b0;
        dq_i = 4'hA;
        // a rising select clears the link logic before the first frame
        #1 cs_n = 1'b1;
    end

    // one frame, link clock runs only inside it
    task automatic xfer(input logic [15:0] bits, input int nclk,
                        input bit quad, output logic [7:0] rd);
        int opc;
        opc = quad ? 2 : 8;
        rd  = 8'h00;
        @(posedge clk);
        #1 cs_n = 1'b0;
        for (int i = 0; i < nclk; i++) begin
            if (i >= opc)
                rd = quad ? {rd[3:0], dq_o} : {rd[6:0], dq_o[1]};
            if (quad && i < 4)
                dq_i = bits[15 - 4 * i -: 4];
            else if (quad)
                dq_i = 4'hF;
            else
                dq_i = {~dq_i[3:1], bits[15 - i]};
            #3 sck = 1'b1;
            #3 sck = 1'b0;
        end
        #3 cs_n = 1'b1;
        // released lanes do not keep their last value
        dq_i = ~dq_i;
        repeat (8) @(posedge clk);
    endtask
endmodule

/* testbench/fms_ctrl_tb.sv */
// self-checking bench for the flash command interpreter
`timescale 1ns/1ps
module fms_ctrl_tb;
    logic       clk, rst_n, ce, wp_n, op_done, area_hit, cont_set, pwr_down;
    logic       sck, cs_n, op_req, op_abort, soft_rst, cmd_reject, quad_mode;
    logic [3:0] dq_i, dq_o, dq_oe_n;
    logic [7:0] op_code, status, rd;
    logic [3:0] oe_seen;
    int         err_count, cmp_count, n_req, n_rst, n_rej, n_abt;
    bit         q;

    fms_ctrl #(.ABORT_CYC(40)) fms_ctrl_i (
        .CLK(clk), .RST_N(rst_n), .CE(ce), .SCK(sck), .CS_N(cs_n),
        .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE_N(dq_oe_n), .WP_N(wp_n),
        .OP_REQ(op_req), .OP_CODE(op_code), .OP_ABORT(op_abort),
        .OP_DONE(op_done), .AREA_HIT(area_hit), .CONT_SET(cont_set),
        .PWR_DOWN(pwr_down), .SOFT_RST(soft_rst), .CMD_REJECT(cmd_reject),
        .QUAD_MODE(quad_mode), .STATUS(status)
    );

    fms_host fms_host_i (
        .clk(clk), .cs_n(cs_n), .sck(sck), .dq_i(dq_i), .dq_o(dq_o)
    );

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // pulse counters
    always @(posedge clk) begin
        n_req <= n_req + int'(op_req === 1'b1);
        n_rst <= n_rst + int'(soft_rst === 1'b1);
        n_rej <= n_rej + int'(cmd_reject === 1'b1);
        n_abt <= n_abt + int'(op_abort === 1'b1);
    end

    // last lane enable seen while the device drove
    always @(posedge clk) begin
        if (dq_oe_n !== 4'hF)
            oe_seen <= dq_oe_n;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chkn(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            err_count++;
            $display("unexpected at %0t: count %0d want %0d", $time, got, exp);
        end
    endtask

    task automatic op(input logic [7:0] b);
        fms_host_i.xfer({b, 8'h00}, q ? 2 : 8, q, rd);
    endtask

    task automatic wr(input logic [7:0] b, input logic [7:0] d);
        fms_host_i.xfer({b, d}, q ? 4 : 16, q, rd);
    endtask

    // quad first byte may predate the frame, so take the repeat
    task automatic rdst();
        fms_host_i.xfer({fms_pkg::OP_ST_READ, 8'h00}, q ? 6 : 16, q, rd);
    endtask

    task automatic done();
        op_done <= 1'b1;
        @(posedge clk);
        op_done <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #100us;
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish;
    end

    initial begin
        {rst_n, op_done, area_hit, cont_set, pwr_down} = 5'h00;
        {ce, wp_n} = 2'h3;
        {err_count, cmp_count, n_req, n_rst, n_rej, n_abt} = '0;
        oe_seen = 4'hF;
        q = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk8(status, fms_pkg::STAT_RST);
        op(fms_pkg::OP_UNLOCK);
        chk8(status, 8'h02);
        rdst();
        chk8(rd, 8'h02);
        chk8({4'h0, oe_seen}, 8'h0D);
        chk8({4'h0, dq_oe_n}, 8'h0F);
        op(fms_pkg::OP_LOCK);
        chk8(status, 8'h00);
        fms_host_i.xfer({fms_pkg::OP_UNLOCK, 8'h00}, 4, 1'b0, rd);
        chk8(status, 8'h00);
        $display("test latch done");
        op(fms_pkg::OP_PAGE);
        chkn(n_rej, 1);
        op(fms_pkg::OP_UNLOCK);
        op(fms_pkg::OP_WIPE_SM);
        chkn(n_req, 1);
        chk8(op_code, fms_pkg::OP_WIPE_SM);
        rdst();
        chk8(rd, 8'h03);
        done();
        chk8(status, 8'h00);
        op(fms_pkg::OP_UNLOCK);
        wr(fms_pkg::OP_ST_WRITE, 8'h04);
        done();
        chk8(status, 8'h04);
        op(fms_pkg::OP_UNLOCK);
        op(fms_pkg::OP_WIPE_ALL);
        chkn(n_rej, 2);
        area_hit <= 1'b1;
        op(fms_pkg::OP_UNLOCK);
        op(fms_pkg::OP_WIPE_LG);
        chkn(n_rej, 3);
        area_hit <= 1'b0;
        $display("test write done");
        op(fms_pkg::OP_ARM);
        op(fms_pkg::OP_UNLOCK);
        op(fms_pkg::OP_FIRE);
        chkn(n_rst, 0);
        chk8(status, 8'h06);
        op(fms_pkg::OP_ARM);
        op(fms_pkg::OP_FIRE);
        chkn(n_rst, 1);
        chk8(status, 8'h00);
        op(fms_pkg::OP_UNLOCK);
        op(fms_pkg::OP_WIPE_HB);
        op(fms_pkg::OP_ARM);
        op(fms_pkg::OP_FIRE);
        chkn(n_abt, 1);
        chk8(status, 8'h01);
        repeat (40) @(posedge clk);
        chk8(status, 8'h00);
        pwr_down <= 1'b1;
        op(fms_pkg::OP_ARM);
        op(fms_pkg::OP_FIRE);
        chkn(n_rst, 2);
        pwr_down <= 1'b0;
        $display("test reset done");
        op(fms_pkg::OP_QUAD_EXIT);
        chk8({7'h00, quad_mode}, 8'h00);
        op(fms_pkg::OP_QUAD_EN);
        q = 1'b1;
        chk8({7'h00, quad_mode}, 8'h01);
        op(fms_pkg::OP_UNLOCK);
        rdst();
        chk8(rd, 8'h02);
        chk8({4'h0, oe_seen}, 8'h00);
        op(fms_pkg::OP_READ);
        op(fms_pkg::OP_READ_DO);
        op(fms_pkg::OP_READ_DIO);
        chkn(n_rej, 6);
        @(posedge clk);
        cont_set <= 1'b1;
        @(posedge clk);
        cont_set <= 1'b0;
        op(fms_pkg::OP_QUAD_EXIT);
        chk8({7'h00, quad_mode}, 8'h01);
        op(fms_pkg::OP_QUAD_EXIT);
        chk8({7'h00, quad_mode}, 8'h00);
        q = 1'b0;
        op(fms_pkg::OP_QUAD_EN);
        q = 1'b1;
        op(fms_pkg::OP_ARM);
        op(fms_pkg::OP_FIRE);
        q = 1'b0;
        op(fms_pkg::OP_ARM);
        op(fms_pkg::OP_FIRE);
        chkn(n_rst, 4);
        chk8({7'h00, quad_mode}, 8'h00);
        $display("test quad done");
        op(fms_pkg::OP_UNLOCK);
        wr(fms_pkg::OP_ST_WRITE, 8'h80);
        done();
        chk8(status, 8'h80);
        wp_n <= 1'b0;
        op(fms_pkg::OP_UNLOCK);
        wr(fms_pkg::OP_ST_WRITE, 8'h00);
        chkn(n_rej, 7);
        op(fms_pkg::OP_QUAD_EN);
        q = 1'b1;
        op(fms_pkg::OP_UNLOCK);
        wr(fms_pkg::OP_ST_WRITE, 8'hC0);
        done();
        chk8(status, 8'hC0);
        op(fms_pkg::OP_QUAD_EXIT);
        q = 1'b0;
        op(fms_pkg::OP_UNLOCK);
        wr(fms_pkg::OP_ST_WRITE, 8'h00);
        done();
        chk8(status, 8'h00);
        wp_n <= 1'b1;
        $display("test protect done");
        op(fms_pkg::OP_OTP_ENTER);
        op(fms_pkg::OP_UNLOCK);
        wr(fms_pkg::OP_ST_WRITE, 8'h3C);
        done();
        chk8(status, 8'h80);
        op(fms_pkg::OP_UNLOCK);
        op(fms_pkg::OP_PAGE);
        chkn(n_rej, 8);
        op(fms_pkg::OP_LOCK);
        chk8(status, 8'h00);
        $display("test otp done");
        tally_and_finish;
    end
endmodule
